// ===== shared/jior_pkg.sv
package jior_pkg;

    // ------------------------------------------------------------------
    // Instruction codes delivered by the decoded test access port
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        JIOR_INSTR_OTHER = 3'h0,
        JIOR_INSTR_IO_RECONFIG = 3'h1,
        JIOR_INSTR_DISENGAGE = 3'h2,
        JIOR_INSTR_ENGAGE = 3'h3,
        JIOR_INSTR_PULSE_RECONFIG = 3'h4
    } jior_instr_t;

    // ------------------------------------------------------------------
    // Configuration scheme straps
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        JIOR_PASSIVE_SERIAL_SCHEME = 2'h0,
        JIOR_FAST_PASSIVE_PARALLEL_SCHEME = 2'h1,
        JIOR_ACTIVE_SERIAL_SCHEME = 2'h2,
        JIOR_ACTIVE_PARALLEL_SCHEME = 2'h3
    } jior_scheme_t;

    // ------------------------------------------------------------------
    // Configuration phase, Gray coded along reset, wait, load, user
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        JIOR_PH_RESET = 2'b00,
        JIOR_PH_WAIT = 2'b01,
        JIOR_PH_LOAD = 2'b11,
        JIOR_PH_USER = 2'b10
    } jior_phase_t;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned JIOR_CLK_MHZ = 250;
    localparam int unsigned JIOR_WAIT_US = 230;
    localparam int unsigned JIOR_PULSE_NS = 500;
    localparam int unsigned JIOR_WAIT_CYCLES = JIOR_WAIT_US * JIOR_CLK_MHZ;
    localparam int unsigned JIOR_PULSE_CYCLES =
        (JIOR_PULSE_NS * JIOR_CLK_MHZ + 999) / 1000;
    localparam int unsigned JIOR_CNT_W = 17;
    localparam logic [JIOR_CNT_W-1:0] JIOR_CNT_ZERO = 17'h0_0000;
    localparam logic [JIOR_CNT_W-1:0] JIOR_CNT_ONE = 17'h0_0001;

    // ------------------------------------------------------------------
    // Synchroniser layout and reset values
    // ------------------------------------------------------------------
    localparam int unsigned JIOR_SYNC_W = 3;
    localparam int unsigned JIOR_SYNC_PIN = 0;
    localparam int unsigned JIOR_SYNC_SCHEME_LO = 1;
    localparam logic [JIOR_SYNC_W-1:0] JIOR_SYNC_RST = 3'h0;

endpackage

// ===== rtl/jior_sync2.sv
`timescale 1ns/100ps
`default_nettype none

module jior_sync2
#(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    always_comb
    begin
        meta_nxt = rst ? RST_VAL : asyncIn;
        sync_nxt = rst ? RST_VAL : meta_r;
    end

    always_ff @(posedge clk_sys)
    begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign syncOut = sync_r;

endmodule // jior_sync2

`default_nettype wire

// ===== rtl/jior_reconfig_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// RULE1 - I/O reconfig reloads the I/O config shift chain via test port.
// RULE2 - Host restarts after testing by pulse instruction or pin pulse.
// RULE3 - I/O reconfig instruction is accepted anytime in user mode.
// RULE4 - Host never issues it with config pin low or right after a restart.
// RULE5 - Host waits 230 us after pin rise, pulse or re-engage instruction.
// RULE6 - After power-up host waits 230 us or for status to rise.
// RULE7 - Host keeps order, skips forbidden instructions, e.g. at power-up.
// RULE8 - In active schemes a disengage is always followed later by re-engage.
// RULE9 - Re-engage needs no extra pulse instruction or pin pulse.
// RULE10 - I/O reconfig leaves the status pin as it is.
// RULE11 - Host disengages active controllers on interrupt, re-engages later.
// RULE12 - Disengage before programming idles the active controllers.
// RULE13 - Active controllers re-engage once programming reaches user mode.
// RULE14 - All user I/Os stay high impedance while I/O reconfig executes.
// RULE15 - Disengage not needed when normal modes restart the device.
// RULE16 - Host restarts by pin low for 500 ns or pulse instruction.
// RULE17 - Failed programming after disengage needs a host re-engage.
// RULE18 - Re-engage also restarts configuration in the selected scheme.
// RULE19 - In passive schemes re-engage acts like the pulse instruction.
// RULE20 - Host ends each I/O reconfig flow with a test port reset.
module jior_reconfig_ctrl
    import jior_pkg::*;
#(
    parameter int unsigned WAIT_CYCLES = JIOR_WAIT_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic instrValid,
    input wire logic [2:0] instrCode,
    input wire logic tapReset,
    input wire logic configPinN,
    input wire logic [1:0] schemeSel,
    input wire logic configLoaded,
    input wire logic jtagProgDone,
    output logic ioChainShiftEn,
    output logic userIoHiZ,
    output logic configStatusN,
    output logic configRun,
    output logic activeEngaged,
    output logic instrRefused
);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    logic [JIOR_SYNC_W-1:0] pinSync;
    logic pinN;
    jior_scheme_t scheme;

    jior_sync2 #(
        .WIDTH(JIOR_SYNC_W),
        .RST_VAL(JIOR_SYNC_RST)
    ) uPinSync (
        .clk_sys(clk_sys),
        .rst(rst),
        .asyncIn({schemeSel, configPinN}),
        .syncOut(pinSync)
    );

    assign pinN = pinSync[JIOR_SYNC_PIN];
    assign scheme = jior_scheme_t'(pinSync[JIOR_SYNC_SCHEME_LO +: 2]);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam logic [JIOR_CNT_W-1:0] WAIT_LOAD =
        JIOR_CNT_W'(WAIT_CYCLES);
    localparam logic [JIOR_CNT_W-1:0] PULSE_LOAD =
        JIOR_CNT_W'(JIOR_PULSE_CYCLES);

    jior_phase_t phase_r;
    jior_phase_t phase_nxt;
    logic [JIOR_CNT_W-1:0] cnt_r;
    logic [JIOR_CNT_W-1:0] cnt_nxt;
    logic pinIgnore_r;
    logic pinIgnore_nxt;
    logic ioActive_r;
    logic ioActive_nxt;
    logic engaged_r;
    logic engaged_nxt;
    logic statusN_r;
    logic statusN_nxt;
    logic hiZ_r;
    logic hiZ_nxt;
    logic run_r;
    logic run_nxt;
    logic refused_r;
    logic refused_nxt;

    logic activeScheme;
    logic isIo;
    logic isDis;
    logic isEng;
    logic isPulse;
    logic softRestart;
    logic pinLow;

    always_comb
    begin
        activeScheme = (scheme == JIOR_ACTIVE_SERIAL_SCHEME) ||
                       (scheme == JIOR_ACTIVE_PARALLEL_SCHEME);
        isIo = instrValid && (instrCode == JIOR_INSTR_IO_RECONFIG);
        isDis = instrValid && (instrCode == JIOR_INSTR_DISENGAGE);
        isEng = instrValid && (instrCode == JIOR_INSTR_ENGAGE);
        isPulse = instrValid && (instrCode == JIOR_INSTR_PULSE_RECONFIG);
        // RULE18 engage restarts
        softRestart = isPulse || isEng;
        // The pin is disabled while an engage-driven restart is underway.
        pinLow = !pinN && !pinIgnore_r;

        phase_nxt = phase_r;
        cnt_nxt = cnt_r;
        pinIgnore_nxt = pinIgnore_r;
        ioActive_nxt = ioActive_r;
        engaged_nxt = engaged_r;
        refused_nxt = 1'b0;

        // RULE1 chain reload
        // RULE3 user mode accept
        // The instruction stays current until another one, a port reset or a pin restart.
        if (tapReset || (instrValid && !isIo))
        begin
            ioActive_nxt = 1'b0;
        end
        else if (isIo)
        begin
            // A reset or blanking phase cannot take the chain reload, so
            // the request is dropped and flagged rather than corrupting
            // a configuration that is still starting.
            if ((phase_r == JIOR_PH_LOAD) || (phase_r == JIOR_PH_USER))
            begin
                ioActive_nxt = 1'b1;
            end
            else
            begin
                refused_nxt = 1'b1;
            end
        end

        // RULE12 idle controllers
        if (isDis && activeScheme)
        begin
            engaged_nxt = 1'b0;
        end
        // RULE13 auto re-engage
        if (jtagProgDone)
        begin
            engaged_nxt = 1'b1;
            phase_nxt = JIOR_PH_USER;
        end
        // RULE19 passive same as pulse
        if (isEng)
        begin
            engaged_nxt = 1'b1;
            pinIgnore_nxt = 1'b1;
        end

        case (phase_r)
            JIOR_PH_RESET:
            begin
                if (cnt_r != JIOR_CNT_ZERO)
                begin
                    cnt_nxt = cnt_r - JIOR_CNT_ONE;
                end
                else if (!pinLow)
                begin
                    phase_nxt = JIOR_PH_WAIT;
                    cnt_nxt = WAIT_LOAD;
                    pinIgnore_nxt = 1'b0;
                end
            end
            JIOR_PH_WAIT:
            begin
                if (cnt_r > JIOR_CNT_ONE)
                begin
                    cnt_nxt = cnt_r - JIOR_CNT_ONE;
                end
                else
                begin
                    cnt_nxt = JIOR_CNT_ZERO;
                    phase_nxt = JIOR_PH_LOAD;
                end
            end
            JIOR_PH_LOAD:
            begin
                if (configLoaded && !ioActive_r)
                begin
                    phase_nxt = JIOR_PH_USER;
                end
            end
            JIOR_PH_USER:
            begin
                phase_nxt = JIOR_PH_USER;
            end
            default:
            begin
                phase_nxt = JIOR_PH_RESET;
            end
        endcase

        // Restart requests override every other phase change.
        if (softRestart)
        begin
            phase_nxt = JIOR_PH_RESET;
            cnt_nxt = PULSE_LOAD;
            ioActive_nxt = 1'b0;
        end
        else if (pinLow && (phase_r != JIOR_PH_RESET))
        begin
            phase_nxt = JIOR_PH_RESET;
            cnt_nxt = JIOR_CNT_ZERO;
            ioActive_nxt = 1'b0;
        end

        // RULE10 status untouched
        statusN_nxt = (phase_nxt == JIOR_PH_LOAD) ||
                      (phase_nxt == JIOR_PH_USER);
        // RULE14 tri-state user I/O
        hiZ_nxt = ioActive_nxt || (phase_nxt != JIOR_PH_USER);
        // Active controllers only fetch data while engaged and the chain
        // reload is not holding the configuration off.
        run_nxt = (phase_nxt == JIOR_PH_LOAD) && !ioActive_nxt &&
                  (engaged_nxt || !activeScheme);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            phase_r <= JIOR_PH_RESET;
            cnt_r <= JIOR_CNT_ZERO;
            pinIgnore_r <= 1'b0;
            ioActive_r <= 1'b0;
            engaged_r <= 1'b1;
            statusN_r <= 1'b0;
            hiZ_r <= 1'b1;
            run_r <= 1'b0;
            refused_r <= 1'b0;
        end
        else
        begin
            phase_r <= phase_nxt;
            cnt_r <= cnt_nxt;
            pinIgnore_r <= pinIgnore_nxt;
            ioActive_r <= ioActive_nxt;
            engaged_r <= engaged_nxt;
            statusN_r <= statusN_nxt;
            hiZ_r <= hiZ_nxt;
            run_r <= run_nxt;
            refused_r <= refused_nxt;
        end
    end

    assign ioChainShiftEn = ioActive_r;
    assign userIoHiZ = hiZ_r;
    assign configStatusN = statusN_r;
    assign configRun = run_r;
    assign activeEngaged = engaged_r;
    assign instrRefused = refused_r;

endmodule // jior_reconfig_ctrl

`default_nettype wire

// ===== verification/jior_reconfig_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module jior_reconfig_ctrl_sva
    import jior_pkg::*;
#(
    parameter int unsigned WAIT_CYCLES = JIOR_WAIT_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic instrValid,
    input wire logic [2:0] instrCode,
    input wire logic tapReset,
    input wire logic configPinN,
    input wire logic [1:0] schemeSel,
    input wire logic configLoaded,
    input wire logic jtagProgDone,
    input wire logic ioChainShiftEn,
    input wire logic userIoHiZ,
    input wire logic configStatusN,
    input wire logic configRun,
    input wire logic activeEngaged,
    input wire logic instrRefused
);
    wire logic isIo = instrValid && instrCode == JIOR_INSTR_IO_RECONFIG;
    wire logic isEng = instrValid && instrCode == JIOR_INSTR_ENGAGE;
    wire logic isRst = isEng ||
        (instrValid && instrCode == JIOR_INSTR_PULSE_RECONFIG);
    wire logic isDis = instrValid && instrCode == JIOR_INSTR_DISENGAGE;
    logic [JIOR_CNT_W-1:0] lowCnt_r;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // The low counter measures how long status stayed low before rising.
    always_ff @(posedge clk_sys)
    begin
        if (rst || configStatusN)
            lowCnt_r <= JIOR_CNT_ZERO;
        else
            lowCnt_r <= lowCnt_r + JIOR_CNT_ONE;
    end
chk_io_take:
    assert property (isIo && configStatusN && !tapReset
        |=> ioChainShiftEn && configStatusN) else $error("io not taken");
chk_io_hiz:
    assert property (ioChainShiftEn |-> userIoHiZ) else $error("io driven");
chk_io_refuse:
    assert property (isIo && !configStatusN
        |=> instrRefused && !ioChainShiftEn) else $error("io not refused");
chk_restart_go:
    assert property (isRst |=> !configStatusN && !configRun && userIoHiZ
        && !ioChainShiftEn) else $error("no restart");
chk_engage_set:
    assert property (isEng |=> activeEngaged) else $error("not engaged");
chk_disengage_idle:
    assert property (isDis && schemeSel[1] |=> !activeEngaged)
        else $error("not idle");
chk_auto_engage:
    assert property (jtagProgDone && !instrValid |=> activeEngaged)
        else $error("no auto engage");
chk_wait_len:
    assert property ($rose(configStatusN) |-> lowCnt_r >= WAIT_CYCLES)
        else $error("wait too short");
endmodule // jior_reconfig_ctrl_sva
bind jior_reconfig_ctrl jior_reconfig_ctrl_sva #(
    .WAIT_CYCLES(WAIT_CYCLES)
) u_jior_reconfig_ctrl_sva (
    .clk_sys(clk_sys), .rst(rst), .instrValid(instrValid),
    .instrCode(instrCode), .tapReset(tapReset), .configPinN(configPinN),
    .schemeSel(schemeSel), .configLoaded(configLoaded),
    .jtagProgDone(jtagProgDone), .ioChainShiftEn(ioChainShiftEn),
    .userIoHiZ(userIoHiZ), .configStatusN(configStatusN),
    .configRun(configRun), .activeEngaged(activeEngaged),
    .instrRefused(instrRefused)
);
`default_nettype wire

// ===== verification/jior_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module jior_host_model
(
    input wire logic clk_sys,
    output logic instrValid,
    output logic [2:0] instrCode,
    output logic tapReset,
    output logic configPinN
);
    initial
    begin
        instrValid = 1'b0;
        instrCode = 3'h0;
        tapReset = 1'b0;
        configPinN = 1'b1;
    end
    task automatic issue(input logic [2:0] code);
        @(negedge clk_sys);
        instrValid = 1'b1;
        instrCode = code;
        @(negedge clk_sys);
        instrValid = 1'b0;
        instrCode = ~code;
    endtask
    task automatic tap_reset;
        @(negedge clk_sys);
        tapReset = 1'b1;
        @(negedge clk_sys);
        tapReset = 1'b0;
    endtask
    task automatic pin_pulse(input int n);
        @(negedge clk_sys);
        configPinN = 1'b0;
        repeat (n) @(negedge clk_sys);
        configPinN = 1'b1;
    endtask
endmodule // jior_host_model
`default_nettype wire

// ===== verification/jior_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import jior_pkg::*;
    localparam int unsigned WAIT_SIM = 20;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic configLoaded = 1'b0;
    logic jtagProgDone = 1'b0;
    logic [1:0] schemeSel = JIOR_ACTIVE_SERIAL_SCHEME;
    logic instrValid, tapReset, configPinN, ioChainShiftEn, userIoHiZ;
    logic configStatusN, configRun, activeEngaged, instrRefused;
    logic [2:0] instrCode;
    int n_mismatch = 0;
    int checks = 0;
    always #2 clk_sys = ~clk_sys;
    jior_host_model u_jior_host_model (.clk_sys(clk_sys),
        .instrValid(instrValid), .instrCode(instrCode),
        .tapReset(tapReset), .configPinN(configPinN));
    jior_reconfig_ctrl #(.WAIT_CYCLES(WAIT_SIM)) u_jior_reconfig_ctrl (
        .clk_sys(clk_sys), .rst(rst), .instrValid(instrValid),
        .instrCode(instrCode), .tapReset(tapReset), .configPinN(configPinN),
        .schemeSel(schemeSel), .configLoaded(configLoaded),
        .jtagProgDone(jtagProgDone), .ioChainShiftEn(ioChainShiftEn),
        .userIoHiZ(userIoHiZ), .configStatusN(configStatusN),
        .configRun(configRun), .activeEngaged(activeEngaged),
        .instrRefused(instrRefused));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(input string what, input logic e, input logic g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s exp %b got %b", what, e, g);
        end
    endtask
    // Status high is the host's cue that the wait is over.
    task automatic wait_up(output int n);
        n = 0;
        while (configStatusN !== 1'b1 && n < 400)
        begin
            @(negedge clk_sys);
            n++;
        end
        cmp("status", 1'b1, configStatusN);
    endtask
    task automatic io_on;
        u_jior_host_model.issue(JIOR_INSTR_IO_RECONFIG);
        cmp("shift", 1'b1, ioChainShiftEn);
        cmp("status", 1'b1, configStatusN);
        cmp("hiz", 1'b1, userIoHiZ);
    endtask
    task automatic t_power_up;
        int n;
        u_jior_host_model.issue(JIOR_INSTR_IO_RECONFIG);
        cmp("refused", 1'b1, instrRefused);
        cmp("shift", 1'b0, ioChainShiftEn);
        wait_up(n);
        cmp("run", 1'b1, configRun);
    endtask
    task automatic t_io_flow;
        io_on();
        configLoaded = 1'b1;
        @(negedge clk_sys);
        cmp("hiz", 1'b1, userIoHiZ);
        u_jior_host_model.tap_reset();
        cmp("shift", 1'b0, ioChainShiftEn);
        @(negedge clk_sys);
        cmp("hiz", 1'b0, userIoHiZ);
        io_on();
        // Any other instruction also ends the chain reload.
        u_jior_host_model.issue(JIOR_INSTR_OTHER);
        cmp("shift", 1'b0, ioChainShiftEn);
        cmp("hiz", 1'b0, userIoHiZ);
        u_jior_host_model.tap_reset();
        @(negedge clk_sys);
        cmp("hiz", 1'b0, userIoHiZ);
    endtask
    task automatic t_disengage;
        u_jior_host_model.issue(JIOR_INSTR_DISENGAGE);
        cmp("engaged", 1'b0, activeEngaged);
        @(negedge clk_sys);
        jtagProgDone = 1'b1;
        @(negedge clk_sys);
        jtagProgDone = 1'b0;
        cmp("engaged", 1'b1, activeEngaged);
    endtask
    task automatic t_restart(input logic [2:0] code, input logic [1:0] sch);
        int n;
        logic eng;
        eng = code == JIOR_INSTR_ENGAGE || !sch[1];
        schemeSel = sch;
        repeat (4) @(negedge clk_sys);
        u_jior_host_model.issue(JIOR_INSTR_DISENGAGE);
        cmp("engaged", !sch[1], activeEngaged);
        u_jior_host_model.issue(code);
        cmp("status", 1'b0, configStatusN);
        cmp("hiz", 1'b1, userIoHiZ);
        cmp("engaged", eng, activeEngaged);
        wait_up(n);
        cmp("wait", 1'b1, n >= JIOR_PULSE_CYCLES + WAIT_SIM);
        cmp("run", eng, configRun);
    endtask
    task automatic t_pin;
        int n;
        fork
            u_jior_host_model.pin_pulse(JIOR_PULSE_CYCLES);
        join_none
        repeat (10) @(negedge clk_sys);
        u_jior_host_model.issue(JIOR_INSTR_IO_RECONFIG);
        cmp("refused", 1'b1, instrRefused);
        cmp("status", 1'b0, configStatusN);
        wait_up(n);
        // Pin stays low 114 cycles past the refused request, then the wait.
        cmp("wait", 1'b1, n >= JIOR_PULSE_CYCLES - 11 + WAIT_SIM);
    endtask
    initial
    begin
        #20000;
        n_mismatch++;
        finish_test();
    end
    initial
    begin
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        t_power_up();
        t_io_flow();
        t_disengage();
        t_restart(JIOR_INSTR_PULSE_RECONFIG,
            JIOR_ACTIVE_SERIAL_SCHEME);
        t_restart(JIOR_INSTR_ENGAGE,
            JIOR_ACTIVE_PARALLEL_SCHEME);
        t_restart(JIOR_INSTR_ENGAGE,
            JIOR_PASSIVE_SERIAL_SCHEME);
        t_restart(JIOR_INSTR_PULSE_RECONFIG,
            JIOR_FAST_PASSIVE_PARALLEL_SCHEME);
        t_pin();
        finish_test();
    end
endmodule // tb
`default_nettype wire
